// *** design/cdi_consts.svh ***
// constants for the instruction decoder: field positions, reset values, counts
`ifndef CDI_CONSTS_SVH
`define CDI_CONSTS_SVH

// first instruction word layout
`define CDI_OP_MSB 15
`define CDI_OP_LSB 11
`define CDI_LONG_BIT 10
`define CDI_MODA_BIT 9
`define CDI_MODB_BIT 8
`define CDI_RD_MSB 7
`define CDI_RD_LSB 4
`define CDI_RS_MSB 3
`define CDI_RS_LSB 0

// instruction lengths in bytes
`define CDI_LEN_SHORT 16'h0002
`define CDI_LEN_LONG 16'h0004

// reset values
`define CDI_PC_RESET 16'h0000
`define CDI_WORD_RESET 16'h0000

// sizes and step counts
`define CDI_STACK_DEPTH 16
`define CDI_BITMEM_WORDS 16
`define CDI_DIV_STEPS 32
`define CDI_PAGE_WIDTH 10

`endif

// *** design/cdi_pkg.sv ***
// types shared by the instruction decoder and its bench
package cdi_pkg;

    typedef enum logic [4:0] {
        NOP_OP = 5'h00,
        ADD_WITH_CARRY_OP = 5'h01,
        SUBTRACT_WITH_BORROW_OP = 5'h02,
        PRODUCT_OP = 5'h03,
        LONG_QUOTIENT_OP = 5'h04,
        BIT_COPY_OP = 5'h05,
        MASKED_BYTE_MODIFY_OP = 5'h06,
        COMPARE_DECREMENT_OP = 5'h07,
        COMPARE_INCREMENT_OP = 5'h08,
        NORMALIZE_COUNT_OP = 5'h09,
        SIGN_SHIFT_RIGHT_OP = 5'h0a,
        BYTE_EXTEND_MOVE_OP = 5'h0b,
        BRANCH_IF_BIT_SET_OP = 5'h0c,
        BRANCH_IF_BIT_CLEAR_OP = 5'h0d,
        PUSH_AND_CALL_OP = 5'h0e,
        CONTEXT_SWAP_OP = 5'h0f,
        TRAP_OP = 5'h10,
        SUBROUTINE_RETURN_OP = 5'h11,
        LEGACY_SLEEP_OP = 5'h12,
        PAGE_EXTENSION_SEQ_OP = 5'h13,
        ACCUMULATOR_LOAD_STORE_OP = 5'h14
    } cdi_op_t;

    // first instruction word
    typedef struct packed {
        cdi_op_t op;
        logic long_form;
        logic mod_a;
        logic mod_b;
        logic [3:0] rd;
        logic [3:0] rs;
    } cdi_instr_t;

    typedef struct packed {
        logic v;
        logic c;
        logic z;
        logic n;
    } cdi_flags_t;

    typedef struct packed {
        logic [15:0] res;
        logic c;
        logic v;
    } cdi_alu_t;

    typedef enum logic [0:0] {
        ST_DECODE = 1'b0,
        ST_DIVIDE = 1'b1
    } cdi_state_t;

endpackage : cdi_pkg

// *** design/cdi_divider.sv ***
// iterative restoring divider, 32-by-16 bit, signed or unsigned
`timescale 1ns/1ps
`include "cdi_consts.svh"
module cdi_divider #(
    parameter int STEPS = `CDI_DIV_STEPS
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // request
    input wire logic start_in,
    input wire logic signed_in,
    input wire logic [31:0] dividend_in,
    input wire logic [15:0] divisor_in,
    // result
    output logic busy_out,
    output logic done_out,
    output logic [31:0] quotient_out,
    output logic [15:0] remainder_out
);
    logic [16:0] part;
    logic [31:0] quo;
    logic [15:0] dsr;
    logic [5:0] count;
    logic neg_q;
    logic neg_r;
    logic [16:0] next_part;
    logic [31:0] next_quo;
    logic [17:0] trial;

    always_comb begin
        trial = {1'b0, part[15:0], quo[31]} - {2'b00, dsr};
        next_quo = {quo[30:0], ~trial[17]};
        next_part = trial[17] ? {part[15:0], quo[31]} : trial[16:0];
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            busy_out <= 1'b0;
            count <= '0;
            part <= '0;
            quo <= '0;
            dsr <= '0;
            neg_q <= 1'b0;
            neg_r <= 1'b0;
        end else if (start_in && !busy_out) begin
            busy_out <= 1'b1;
            count <= 6'(STEPS);
            part <= 17'h00000;
            quo <= (signed_in && dividend_in[31]) ? -dividend_in : dividend_in;
            dsr <= (signed_in && divisor_in[15]) ? -divisor_in : divisor_in;
            neg_q <= signed_in && (dividend_in[31] ^ divisor_in[15]);
            neg_r <= signed_in && dividend_in[31];
        end else if (busy_out) begin
            part <= next_part;
            quo <= next_quo;
            count <= count - 6'h01;
            busy_out <= (count != 6'h01);
        end
    end

    // results registered on the last step, done pulses once
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            done_out <= 1'b0;
            quotient_out <= '0;
            remainder_out <= '0;
        end else begin
            done_out <= busy_out && (count == 6'h01);
            if (busy_out && (count == 6'h01)) begin
                quotient_out <= neg_q ? -next_quo : next_quo;
                remainder_out <= neg_r ? -next_part[15:0] : next_part[15:0];
            end
        end
    end

endmodule : cdi_divider

// *** design/cdi_core.sv ***
// instruction decode and execute core fed by the fetch path
`timescale 1ns/1ps
`include "cdi_consts.svh"
// What this block does
// [RQ1] add or subtract word or byte, optional carry, 2 or 4 bytes
// [RQ2] signed or unsigned 16x16 multiply of two registers, 2 bytes
// [RQ3] divide low muldiv register by a register, 16/16 bit
// [RQ4] divide 32-bit muldiv pair by a 16-bit register
// [RQ5] copy a direct bit, optionally inverted, to another, 4 bytes
// [RQ6] modify masked high or low byte of a bit word, 4 bytes
// [RQ7] compare word with register, then decrement it by one or two
// [RQ8] compare word with register, then increment it by one or two
// [RQ9] count normalize shifts of a register into another, 2 bytes
// [RQ10] arithmetic right shift of a register keeping sign, 2 bytes
// [RQ11] byte to word move, sign or zero extended, 2 or 4 bytes
// [RQ12] branch relative if bit set, variant clears the bit
// [RQ13] branch relative if bit clear, variant sets the bit
// [RQ14] push register then call absolute address, 4 bytes
// [RQ15] push register then load it with a word, 4 bytes
// [RQ16] enter service routine by immediate trap number, 2 bytes
// [RQ17] return restores address, variant also pops a register
// [RQ18] legacy sleep decodes but does nothing, 4 bytes
// [RQ19] start extended page sequence, optional register mode
// [RQ20] accumulator load and register store, 4 bytes each
// [RQ21] first word decides 2 or 4 byte program counter advance
module cdi_core #(
    parameter int STACK_DEPTH = `CDI_STACK_DEPTH,
    parameter int PAGE_WIDTH = `CDI_PAGE_WIDTH
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // fetch path
    input wire logic fetch_valid_in,
    input wire logic [31:0] fetch_data_in,
    output logic fetch_ready_out,
    output logic [15:0] fetch_addr_out,
    // status
    output cdi_pkg::cdi_flags_t flags_out,
    output logic [31:0] md_out,
    output logic [31:0] acc_out,
    output logic ext_active_out,
    output logic ext_reg_mode_out,
    output logic [PAGE_WIDTH-1:0] ext_page_out,
    // register peek
    input wire logic [3:0] dbg_sel_in,
    output logic [15:0] dbg_data_out
);
    import cdi_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    cdi_state_t state;
    cdi_instr_t ins;
    logic [15:0] ext;
    logic take;
    logic [15:0] len;
    logic [15:0] pc;
    logic [15:0] gpr [16];
    logic [15:0] bitmem [`CDI_BITMEM_WORDS];
    logic [15:0] stack [STACK_DEPTH];
    logic [SP_W-1:0] sp;
    logic [2:0] ext_count;
    // next values from the execute stage
    logic [15:0] next_pc;
    cdi_flags_t next_flags;
    logic [31:0] next_md;
    logic [31:0] next_acc;
    logic gpr_we;
    logic [15:0] gpr_wd;
    logic [3:0] gpr_wa;
    logic mem_we;
    logic [3:0] mem_wa;
    logic [15:0] mem_wd;
    logic [1:0] push_n;
    logic [1:0] pop_n;
    logic [15:0] push_a;
    logic [15:0] push_b;
    logic div_start;
    logic ext_load;
    // operands and helpers
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] rs_val;
    logic [15:0] bit_word;
    logic bit_val;
    logic [15:0] bmask;
    logic [15:0] bdata;
    logic [31:0] product;
    logic [31:0] div_dividend;
    cdi_alu_t alu;
    // divider
    logic div_busy;
    logic div_done;
    logic [31:0] div_quo;
    logic [15:0] div_rem;

    // add or subtract, byte forms carried in the upper half
    function automatic cdi_alu_t alu_add(input logic [15:0] x, input logic [15:0] y,
                                         input logic cin, input logic sub,
                                         input logic byte_op);
        logic [15:0] ax;
        logic [15:0] bx;
        logic cy;
        logic [16:0] s;
        cdi_alu_t r;
        cy = sub ? ~cin : cin;
        ax = byte_op ? {x[7:0], 8'h00} : x;
        bx = sub ? ~y : y;
        bx = byte_op ? {bx[7:0], {8{cy}}} : bx;
        s = {1'b0, ax} + {1'b0, bx} + {16'h0000, cy};
        r.res = byte_op ? {8'h00, s[15:8]} : s[15:0];
        r.c = s[16] ^ sub;
        r.v = (ax[15] == bx[15]) && (s[15] != ax[15]);
        return r;
    endfunction : alu_add

    function automatic cdi_flags_t flags_of(input cdi_alu_t r, input logic byte_op);
        cdi_flags_t f;
        f.v = r.v;
        f.c = r.c;
        f.z = byte_op ? (r.res[7:0] == 8'h00) : (r.res == 16'h0000);
        f.n = byte_op ? r.res[7] : r.res[15];
        return f;
    endfunction : flags_of

    // shifts needed to bring the top set bit to bit 15
    function automatic logic [15:0] norm_count(input logic [15:0] w);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (w[i]) begin
                r = 16'(15 - i);
            end
        end
        return r;
    endfunction : norm_count

    function automatic logic [15:0] bit_put(input logic [15:0] w, input logic [3:0] p,
                                            input logic v);
        logic [15:0] r;
        r = w;
        r[p] = v;
        return r;
    endfunction : bit_put

    // long-form ops are fixed 4, short ops fixed 2, the rest follow the long bit
    function automatic logic [15:0] instr_len(input cdi_instr_t i);
        logic [15:0] r;
        r = `CDI_LEN_SHORT;
        case (i.op)
            BIT_COPY_OP, MASKED_BYTE_MODIFY_OP, BRANCH_IF_BIT_SET_OP,
            BRANCH_IF_BIT_CLEAR_OP, PUSH_AND_CALL_OP, CONTEXT_SWAP_OP,
            LEGACY_SLEEP_OP, ACCUMULATOR_LOAD_STORE_OP: r = `CDI_LEN_LONG;
            ADD_WITH_CARRY_OP, SUBTRACT_WITH_BORROW_OP, COMPARE_DECREMENT_OP,
            COMPARE_INCREMENT_OP, BYTE_EXTEND_MOVE_OP, PAGE_EXTENSION_SEQ_OP: begin
                r = i.long_form ? `CDI_LEN_LONG : `CDI_LEN_SHORT;
            end
            default: r = `CDI_LEN_SHORT;
        endcase
        return r;
    endfunction : instr_len

    assign ins = cdi_instr_t'(fetch_data_in[15:0]);
    assign ext = fetch_data_in[31:16];
    assign fetch_ready_out = (state == ST_DECODE);
    assign take = fetch_valid_in && fetch_ready_out;
    assign len = instr_len(ins); // RQ21
    assign fetch_addr_out = pc;
    assign ext_active_out = (ext_count != 3'h0);

    always_comb begin
        a = gpr[ins.rd];
        rs_val = gpr[ins.rs];
        b = ins.long_form ? ext : rs_val;
        bit_word = bitmem[ext[15:12]];
        bit_val = bit_word[ext[11:8]];
        bmask = ins.mod_a ? {ext[15:8], 8'h00} : {8'h00, ext[15:8]};
        bdata = ins.mod_a ? {ext[7:0], 8'h00} : {8'h00, ext[7:0]};
        product = ins.mod_a ? 32'($signed(a) * $signed(rs_val)) : 32'(a * rs_val);
        div_dividend = ins.mod_b ? md_out
                     : (ins.mod_a ? {{16{md_out[15]}}, md_out[15:0]}
                                  : {16'h0000, md_out[15:0]});
        alu = alu_add(a, b, 1'b0, 1'b1, 1'b0);
        next_pc = pc;
        next_flags = flags_out;
        next_md = md_out;
        next_acc = acc_out;
        gpr_we = 1'b0;
        gpr_wa = ins.rd;
        gpr_wd = a;
        mem_we = 1'b0;
        mem_wa = ext[7:4];
        mem_wd = 16'h0000;
        push_n = 2'h0;
        pop_n = 2'h0;
        push_a = a;
        push_b = 16'h0000;
        div_start = 1'b0;
        ext_load = 1'b0;
        if (take) begin
            next_pc = pc + len; // RQ21
            case (ins.op)
                ADD_WITH_CARRY_OP, SUBTRACT_WITH_BORROW_OP: begin
                    alu = alu_add(a, b, ins.mod_a & flags_out.c,
                                  ins.op == SUBTRACT_WITH_BORROW_OP, ins.mod_b); // RQ1
                    gpr_we = 1'b1;
                    gpr_wd = ins.mod_b ? {a[15:8], alu.res[7:0]} : alu.res; // RQ1
                    next_flags = flags_of(alu, ins.mod_b);
                end
                PRODUCT_OP: begin
                    next_md = product; // RQ2
                    next_flags = '{v: 1'b0, c: 1'b0, z: product == 32'h00000000,
                                   n: product[31]};
                end
                LONG_QUOTIENT_OP: begin
                    div_start = 1'b1; // RQ3 RQ4
                    next_flags.v = (rs_val == 16'h0000);
                end
                BIT_COPY_OP: begin
                    mem_we = 1'b1;
                    mem_wd = bit_put(bitmem[ext[7:4]], ext[3:0], bit_val ^ ins.mod_a); // RQ5
                end
                MASKED_BYTE_MODIFY_OP: begin
                    mem_we = 1'b1;
                    mem_wa = ins.rd;
                    mem_wd = (bitmem[ins.rd] & ~bmask) | (bdata & bmask); // RQ6
                end
                COMPARE_DECREMENT_OP, COMPARE_INCREMENT_OP: begin
                    next_flags = flags_of(alu, 1'b0); // RQ7 RQ8
                    gpr_we = 1'b1;
                    if (ins.op == COMPARE_DECREMENT_OP) begin
                        gpr_wd = a - (ins.mod_a ? 16'h0002 : 16'h0001); // RQ7
                    end else begin
                        gpr_wd = a + (ins.mod_a ? 16'h0002 : 16'h0001); // RQ8
                    end
                end
                NORMALIZE_COUNT_OP: begin
                    gpr_we = 1'b1;
                    gpr_wd = norm_count(rs_val); // RQ9
                    next_flags.z = (rs_val == 16'h0000);
                end
                SIGN_SHIFT_RIGHT_OP: begin
                    gpr_we = 1'b1;
                    gpr_wd = 16'($signed(a) >>> rs_val[3:0]); // RQ10
                    next_flags.n = a[15];
                    next_flags.z = (gpr_wd == 16'h0000);
                end
                BYTE_EXTEND_MOVE_OP: begin
                    gpr_we = 1'b1;
                    gpr_wd = {{8{ins.mod_a & b[7]}}, b[7:0]}; // RQ11
                end
                BRANCH_IF_BIT_SET_OP, BRANCH_IF_BIT_CLEAR_OP: begin
                    if (bit_val == (ins.op == BRANCH_IF_BIT_SET_OP)) begin
                        next_pc = pc + len + {{7{ext[7]}}, ext[7:0], 1'b0}; // RQ12 RQ13
                        mem_we = ins.mod_a;
                        mem_wa = ext[15:12];
                        mem_wd = bit_put(bit_word, ext[11:8], ~bit_val); // RQ12 RQ13
                    end
                end
                PUSH_AND_CALL_OP: begin
                    push_n = 2'h2; // RQ14
                    push_b = pc + len;
                    next_pc = ext;
                end
                CONTEXT_SWAP_OP: begin
                    push_n = 2'h1; // RQ15
                    gpr_we = 1'b1;
                    gpr_wd = ext;
                end
                TRAP_OP: begin
                    push_n = 2'h1; // RQ16
                    push_a = pc + len;
                    next_pc = {6'h00, ins.rd, ins.rs, 2'b00};
                end
                SUBROUTINE_RETURN_OP: begin
                    next_pc = stack[SP_W'(sp - SP_W'(1))]; // RQ17
                    pop_n = ins.mod_a ? 2'h2 : 2'h1;
                    gpr_we = ins.mod_a;
                    gpr_wd = stack[SP_W'(sp - SP_W'(2))]; // RQ17
                end
                LEGACY_SLEEP_OP: begin
                    next_pc = pc + len; // RQ18
                end
                PAGE_EXTENSION_SEQ_OP: begin
                    ext_load = 1'b1; // RQ19
                end
                ACCUMULATOR_LOAD_STORE_OP: begin
                    if (!ins.mod_a) begin
                        next_acc = {a, rs_val}; // RQ20
                    end else begin
                        gpr_we = 1'b1;
                        gpr_wd = ins.mod_b ? acc_out[31:16] : acc_out[15:0]; // RQ20
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state <= ST_DECODE;
        end else begin
            unique case (state)
                ST_DECODE: begin
                    if (div_start) begin
                        state <= ST_DIVIDE;
                    end
                end
                ST_DIVIDE: begin
                    if (div_done) begin
                        state <= ST_DECODE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pc <= `CDI_PC_RESET;
            flags_out <= '0;
            acc_out <= '0;
        end else begin
            pc <= next_pc;
            flags_out <= next_flags;
            acc_out <= next_acc;
        end
    end

    // quotient low, remainder high
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            md_out <= '0;
        end else if (div_done) begin
            md_out <= {div_rem, div_quo[15:0]}; // RQ3 RQ4
        end else begin
            md_out <= next_md;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 16; i++) begin
                gpr[i] <= `CDI_WORD_RESET;
            end
        end else if (gpr_we) begin
            gpr[gpr_wa] <= gpr_wd;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < `CDI_BITMEM_WORDS; i++) begin
                bitmem[i] <= `CDI_WORD_RESET;
            end
        end else if (mem_we) begin
            bitmem[mem_wa] <= mem_wd;
        end
    end

    // register goes below the return address so a return pops it second
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            sp <= '0;
        end else begin
            sp <= SP_W'(sp + SP_W'(push_n) - SP_W'(pop_n)); // RQ14 RQ17
        end
    end

    always_ff @(posedge clock_in) begin
        if (push_n != 2'h0) begin
            stack[sp] <= push_a;
        end
        if (push_n == 2'h2) begin
            stack[SP_W'(sp + SP_W'(1))] <= push_b;
        end
    end

    // extension window covers the next rd[1:0]+1 instructions
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            ext_count <= 3'h0;
            ext_reg_mode_out <= 1'b0;
            ext_page_out <= '0;
        end else if (ext_load) begin
            ext_count <= {1'b0, ins.rd[1:0]} + 3'h1; // RQ19
            ext_reg_mode_out <= ins.mod_a;
            ext_page_out <= PAGE_WIDTH'(b);
        end else if (take && ext_count != 3'h0) begin
            ext_count <= ext_count - 3'h1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            dbg_data_out <= 16'h0000;
        end else begin
            dbg_data_out <= gpr[dbg_sel_in];
        end
    end

    cdi_divider #(
        .STEPS(`CDI_DIV_STEPS)
    ) u_divider (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .start_in(div_start),
        .signed_in(ins.mod_a),
        .dividend_in(div_dividend),
        .divisor_in(rs_val),
        .busy_out(div_busy),
        .done_out(div_done),
        .quotient_out(div_quo),
        .remainder_out(div_rem)
    );

endmodule : cdi_core

// *** bench/cdi_fetch_model.sv ***
// program memory model on the fetch path of the decoder core
`timescale 1ns/1ps
module cdi_fetch_model (
    // clock and control
    input wire logic clock_in,
    input wire logic run_in,
    // fetch path
    input wire logic [15:0] addr_in,
    output logic valid_out,
    output logic [31:0] data_out
);
    logic [15:0] mem [0:127];
    logic [6:0] wi;
    assign wi = addr_in[7:1];
    initial begin
        valid_out = 1'b0;
        data_out = 32'h0000_0000;
    end
    always @(posedge clock_in) begin
        #2;
        valid_out <= run_in;
        // idle bus shows flipped bits, not the last word
        data_out <= run_in ? {mem[wi + 7'h01], mem[wi]} : ~data_out;
    end
endmodule : cdi_fetch_model

// *** bench/cdi_core_props.sv ***
// port assertions for the decoder core
`timescale 1ns/1ps
module cdi_core_props #(
    parameter int PAGE_WIDTH = 10
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic fetch_valid_in,
    input wire logic [31:0] fetch_data_in,
    input wire logic fetch_ready_out,
    input wire logic [15:0] fetch_addr_out,
    input wire cdi_pkg::cdi_flags_t flags_out,
    input wire logic [31:0] md_out,
    input wire logic [31:0] acc_out,
    input wire logic ext_reg_mode_out,
    input wire logic [PAGE_WIDTH-1:0] ext_page_out
);
    import cdi_pkg::*;
    logic t;
    logic [4:0] op;
    logic [15:0] pc;
    assign t = fetch_valid_in && fetch_ready_out;
    assign op = fetch_data_in[15:11];
    assign pc = fetch_addr_out;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    a_mul_step: assert property (t && op == PRODUCT_OP
        |=> pc == $past(pc) + 16'h0002 && !flags_out.c && !flags_out.v) else $error("mul");
    a_div_stall: assert property (t && op == LONG_QUOTIENT_OP
        |=> !fetch_ready_out ##32 !fetch_ready_out ##1 fetch_ready_out) else $error("div");
    a_stall_hold: assert property (!fetch_ready_out |=> $stable(pc)) else $error("hold");
    a_copy_len: assert property (t && op == BIT_COPY_OP
        |=> pc == $past(pc) + 16'h0004) else $error("copy");
    a_mask_len: assert property (t && op == MASKED_BYTE_MODIFY_OP
        |=> pc == $past(pc) + 16'h0004) else $error("mask");
    a_sleep_idle: assert property (t && op == LEGACY_SLEEP_OP
        |=> pc == $past(pc) + 16'h0004 && $stable(md_out) && $stable(acc_out)
        && $stable(flags_out)) else $error("sleep");
    a_call_dest: assert property (t && op == PUSH_AND_CALL_OP
        |=> pc == $past(fetch_data_in[31:16])) else $error("call");
    a_trap_vec: assert property (t && op == TRAP_OP
        |=> pc == {6'h00, $past(fetch_data_in[7:0]), 2'h0}) else $error("trap");
    a_page_load: assert property (t && op == PAGE_EXTENSION_SEQ_OP && fetch_data_in[10]
        |=> ext_page_out == $past(fetch_data_in[PAGE_WIDTH+15:16])
        && ext_reg_mode_out == $past(fetch_data_in[9])) else $error("page");
    a_add_len: assert property (t && op inside {ADD_WITH_CARRY_OP, SUBTRACT_WITH_BORROW_OP}
        |=> pc == $past(pc) + ($past(fetch_data_in[10]) ? 16'h0004 : 16'h0002))
        else $error("add");
endmodule : cdi_core_props
bind cdi_core cdi_core_props #(.PAGE_WIDTH(PAGE_WIDTH)) u_props (.*);

// *** bench/tb_cdi_core.sv ***
// self-checking bench for the decoder core
`timescale 1ns/1ps
`define CK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin failures++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_cdi_core;
    import cdi_pkg::*;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic run = 1'b0;
    logic [3:0] dbg_sel_in = 4'h0;
    logic fetch_valid_in, fetch_ready_out, ext_active_out, ext_reg_mode_out;
    logic [31:0] fetch_data_in, md_out, acc_out;
    logic [15:0] fetch_addr_out, dbg_data_out, pa;
    logic [9:0] ext_page_out;
    cdi_flags_t flags_out;
    int failures = 0;
    int checks_done = 0;
    always #5 clock_in = ~clock_in;
    cdi_core u_dut (.*);
    cdi_fetch_model u_fetch (.clock_in(clock_in), .run_in(run), .addr_in(fetch_addr_out),
        .valid_out(fetch_valid_in), .data_out(fetch_data_in));
    task automatic put(logic [4:0] op, logic [2:0] m, logic [3:0] rd, logic [3:0] rs);
        u_fetch.mem[pa[7:1]] = {op, m, rd, rs};
        pa = pa + 16'h0002;
    endtask : put
    task automatic ext(logic [15:0] w);
        u_fetch.mem[pa[7:1]] = w;
        pa = pa + 16'h0002;
    endtask : ext
    task automatic ld(logic [3:0] rd, logic [15:0] v);
        put(CONTEXT_SWAP_OP, 3'h0, rd, 4'h0);
        ext(v);
    endtask : ld
    // trap far away
    task automatic away;
        put(TRAP_OP, 3'h0, 4'hf, 4'hf);
    endtask : away
    task automatic start;
        for (int i = 0; i < 128; i++) u_fetch.mem[i] = 16'h0000;
        pa = 16'h0000;
    endtask : start
    task automatic go(logic [15:0] stop);
        int n;
        n = 0;
        @(posedge clock_in);
        #1 rst_n_in <= 1'b0;
        repeat (6) @(posedge clock_in);
        #1 rst_n_in <= 1'b1;
        run <= 1'b1;
        while (fetch_addr_out !== stop && n < 200) begin
            @(posedge clock_in);
            #1 n++;
        end
        run <= 1'b0;
        `CK("pc", stop, fetch_addr_out)
        repeat (40) @(posedge clock_in);
    endtask : go
    task automatic peek(logic [3:0] r, logic [15:0] ex);
        #1 dbg_sel_in <= r;
        repeat (2) @(posedge clock_in);
        #1 `CK("gpr", ex, dbg_data_out)
    endtask : peek
    task automatic t_arith;
        start;
        ld(4'h1, 16'h1234);
        ld(4'h2, 16'h0f0f);
        put(ADD_WITH_CARRY_OP, 3'h0, 4'h1, 4'h2);
        put(NORMALIZE_COUNT_OP, 3'h0, 4'h4, 4'h2);
        ld(4'h5, 16'h8000);
        put(SIGN_SHIFT_RIGHT_OP, 3'h0, 4'h5, 4'h4);
        put(BYTE_EXTEND_MOVE_OP, 3'h6, 4'h6, 4'h0);
        ext(16'h0080);
        put(BYTE_EXTEND_MOVE_OP, 3'h4, 4'h7, 4'h0);
        ext(16'h0080);
        put(SUBTRACT_WITH_BORROW_OP, 3'h4, 4'h2, 4'h0);
        ext(16'h0f0e);
        put(COMPARE_INCREMENT_OP, 3'h6, 4'h1, 4'h0);
        ext(16'h0000);
        put(COMPARE_DECREMENT_OP, 3'h0, 4'h2, 4'h2);
        go(16'h0024);
        `CK("z", 1'b1, flags_out.z)
        peek(4'h1, 16'h2145);
        peek(4'h2, 16'h0000);
        peek(4'h4, 16'h0004);
        peek(4'h5, 16'hf800);
        peek(4'h6, 16'hff80);
        peek(4'h7, 16'h0080);
    endtask : t_arith
    task automatic t_divide;
        start;
        ld(4'h1, 16'h0007);
        ld(4'h2, 16'h0064);
        ld(4'h3, 16'h0003);
        put(PRODUCT_OP, 3'h0, 4'h2, 4'h3);
        put(LONG_QUOTIENT_OP, 3'h0, 4'h0, 4'h1);
        go(16'h0010);
        `CK("md", 32'h0006_002a, md_out)
        start;
        ld(4'h4, 16'hfff9);
        ld(4'h1, 16'h0002);
        put(PRODUCT_OP, 3'h2, 4'h4, 4'h1);
        put(LONG_QUOTIENT_OP, 3'h3, 4'h0, 4'h1);
        go(16'h000c);
        `CK("md", 32'h0000_fff9, md_out)
    endtask : t_divide
    task automatic t_flow;
        start;
        ld(4'h9, 16'h5a5a);
        put(PUSH_AND_CALL_OP, 3'h0, 4'h9, 4'h0);
        ext(16'h0040);
        put(TRAP_OP, 3'h0, 4'h1, 4'h2);
        put(LEGACY_SLEEP_OP, 3'h0, 4'h0, 4'h0);
        ext(16'h0000);
        pa = 16'h0040;
        put(SUBROUTINE_RETURN_OP, 3'h2, 4'h7, 4'h0);
        pa = 16'h0048;
        put(SUBROUTINE_RETURN_OP, 3'h0, 4'h0, 4'h0);
        go(16'h000e);
        peek(4'h7, 16'h5a5a);
    endtask : t_flow
    task automatic t_bits;
        start;
        put(MASKED_BYTE_MODIFY_OP, 3'h0, 4'h3, 4'h0);
        ext(16'h0303);
        put(BIT_COPY_OP, 3'h2, 4'h0, 4'h0);
        ext(16'h3031);
        put(BRANCH_IF_BIT_SET_OP, 3'h2, 4'h0, 4'h0);
        ext(16'h3004);
        away;
        pa = 16'h0014;
        put(BRANCH_IF_BIT_CLEAR_OP, 3'h0, 4'h0, 4'h0);
        ext(16'h3104);
        away;
        pa = 16'h0020;
        put(BRANCH_IF_BIT_SET_OP, 3'h0, 4'h0, 4'h0);
        ext(16'h3004);
        put(BRANCH_IF_BIT_CLEAR_OP, 3'h2, 4'h0, 4'h0);
        ext(16'h3104);
        away;
        pa = 16'h0030;
        put(BRANCH_IF_BIT_SET_OP, 3'h0, 4'h0, 4'h0);
        ext(16'h3104);
        away;
        go(16'h003c);
    endtask : t_bits
    task automatic t_ext;
        start;
        ld(4'h1, 16'hbeef);
        ld(4'h2, 16'hcafe);
        put(ACCUMULATOR_LOAD_STORE_OP, 3'h0, 4'h1, 4'h2);
        ext(16'h0000);
        put(ACCUMULATOR_LOAD_STORE_OP, 3'h3, 4'h3, 4'h0);
        ext(16'h0000);
        put(PAGE_EXTENSION_SEQ_OP, 3'h6, 4'h1, 4'h0);
        ext(16'h0155);
        go(16'h0014);
        `CK("acc", 32'hbeef_cafe, acc_out)
        `CK("page", 10'h155, ext_page_out)
        `CK("regm", 1'b1, ext_reg_mode_out)
        `CK("act", 1'b1, ext_active_out)
        peek(4'h3, 16'hbeef);
        peek(4'h1, 16'hbeef);
    endtask : t_ext
    task automatic results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    initial begin
        t_arith;
        t_divide;
        t_flow;
        t_bits;
        t_ext;
        results;
    end
    initial begin
        repeat (5000) @(posedge clock_in);
        failures++;
        results;
    end
endmodule : tb_cdi_core
